// ### verilog/lsec_params.svh
// constants of the legacy simd exception checker
`ifndef LSEC_PARAMS_SVH
`define LSEC_PARAMS_SVH
// apb register byte offsets
`define LSEC_ADDR_W       8
`define LSEC_OFS_CR0      8'h00
`define LSEC_OFS_CR4      8'h04
`define LSEC_OFS_FEAT     8'h08
`define LSEC_OFS_ALIGN    8'h0C
`define LSEC_OFS_STATUS   8'h10
`define LSEC_OFS_COUNT    8'h14
// field positions
`define LSEC_BIT_EM       2
`define LSEC_BIT_TS       3
`define LSEC_BIT_OSFXSR   9
`define LSEC_BIT_OSXMM    10
`define LSEC_BIT_ACEN     0
`define LSEC_FEAT_W       4
`define LSEC_ST_FAULT_LO  0
`define LSEC_ST_CAT_LO    4
`define LSEC_ST_VEC_LO    8
`define LSEC_CNT_W        16
`define LSEC_CANON_MSB    47
`define LSEC_CPL_USER     2'h3
// reset values
`define LSEC_RST_EM       1'h0
`define LSEC_RST_TS       1'h0
`define LSEC_RST_OSFXSR   1'h0
`define LSEC_RST_OSXMM    1'h0
`define LSEC_RST_ACEN     1'h0
`define LSEC_RST_FEAT     4'hF
// interrupt vectors
`define LSEC_VEC_NONE     8'h00
`define LSEC_VEC_UD       8'h06
`define LSEC_VEC_NM       8'h07
`define LSEC_VEC_SS       8'h0C
`define LSEC_VEC_GP       8'h0D
`define LSEC_VEC_PF       8'h0E
`define LSEC_VEC_MF       8'h10
`define LSEC_VEC_AC       8'h11
`define LSEC_VEC_XM       8'h13
// address limits, offsets of an operand's last byte
`define LSEC_RM_LIMIT     33'h0_0000_FFFF
`define LSEC_LAST_OP8     33'h0_0000_0007
`define LSEC_LAST_OP16    33'h0_0000_000F
`define LSEC_ERR_ZERO     32'h0000_0000
`endif

// ### verilog/lsec_pkg.sv
// types of the legacy simd exception checker
package lsec_pkg;
  typedef enum logic [1:0] {MODE_REAL, MODE_V86, MODE_PROT, MODE_LONG} lsec_mode_e;
  typedef enum logic [1:0] {GRP_FP_ALIGN16, GRP_FP_NOALIGN, GRP_NO_FP} lsec_group_e;
  typedef enum logic [3:0] {FLT_NONE, FLT_UD, FLT_NM, FLT_MF, FLT_SS, FLT_GP, FLT_PF, FLT_AC,
                            FLT_XM} lsec_fault_e;
  typedef enum logic [3:0] {CAT_NONE, CAT_TRAP, CAT_INTR, CAT_FETCH, CAT_DECODE,
                            CAT_EXEC} lsec_cat_e;
  typedef struct packed {
    logic        valid;
    lsec_group_e group;
    lsec_mode_e  mode;
    logic [1:0]  cpl;
    logic        lock_prefix;
    logic        mem_form;
    logic [3:0]  feat_need;
    logic        x87_pending;
    logic        simd_unmasked;
    logic        seg_fail;
    logic        seg_stack;
    logic [31:0] ea;
    logic [63:0] lin;
    logic        pf_fail;
    logic [31:0] pf_code;
  } lsec_req_s;
  typedef struct packed {
    logic trap;
    logic intr;
    logic fetch;
    logic decode;
  } lsec_pend_s;
  typedef struct packed {
    logic        valid;
    lsec_cat_e   cat;
    lsec_fault_e fault;
    logic [7:0]  vector;
    logic        err_valid;
    logic [31:0] err_code;
  } lsec_result_s;
  typedef struct packed {
    logic         em;
    logic         ts;
    logic         osfxsr;
    logic         osxmm;
    logic         ac_en;
    logic [3:0]   feat;
    logic [31:0]  prdata;
    logic         pslverr;
    lsec_result_s res;
    logic [15:0]  cnt;
  } lsec_state_s;
endpackage : lsec_pkg

// ### verilog/lsec_check.sv
// exception qualification and category arbitration for legacy simd conversions
// Contract
// - order: previous traps, interrupts, fetch faults, decode faults, execute faults
// - category order fixed; order inside execute category is our own choice
// - fpu emulate flag set gives undefined opcode fault in every mode
// - extended save support flag clear gives undefined opcode fault
// - bus lock prefix gives undefined opcode fault
// - any required feature flag reading zero gives undefined opcode fault
// - pending x87 error gives x87 fault; task switched gives unavailable fault
// - unmasked simd error with simd handler flag clear gives undefined opcode
// - unmasked simd error with simd handler flag set gives simd fault
// - protected/compatibility: illegal stack segment address gives stack fault, code 0
// - 64-bit: non-canonical stack reference gives stack fault, code 0
// - protected/compatibility: illegal data segment address gives protection fault, code 0
// - 64-bit: non-canonical non-stack address gives protection fault, code 0
// - real/v86: operand byte beyond FFFF gives protection fault
// - aligned group: operand not on 16 bytes gives protection fault
// - other groups, not real: enabled check, unaligned, level 3 gives alignment fault
// - three instruction groups, each applies only its own checks
// - simd fault uses vector 19
// - no-fp group checks x87 pending only for register source form
//
// Register access over APB and the register offsets are this design's own decisions.
`include "lsec_params.svh"

module lsec_check
  import lsec_pkg::*;
(
  // clock and reset
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  // apb slave
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [`LSEC_ADDR_W-1:0]  paddr,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  // pipeline request and pending events
  input  wire lsec_req_s                req,
  input  wire lsec_pend_s               pend,
  // arbitrated event
  output lsec_result_s                  res
);

  lsec_state_s st;
  lsec_state_s next_st;

  logic        is_real;
  logic        is_v86;
  logic        in_pm;
  logic        in_64;
  logic        fp_grp;
  logic        a16_grp;
  logic        mem;
  logic        canon_ok;
  logic [32:0] last_byte;
  logic        beyond;
  logic        ud;
  logic        nm;
  logic        mf;
  logic        ss;
  logic        gp;
  logic        pf;
  logic        ac;
  logic        xm;
  logic        setup;
  logic        access;
  logic        mapped;
  logic [31:0] rd_word;
  lsec_fault_e flt;
  lsec_cat_e   cat;

  assign is_real = req.mode == MODE_REAL;
  assign is_v86  = req.mode == MODE_V86;
  assign in_pm   = req.mode == MODE_PROT;
  assign in_64   = req.mode == MODE_LONG;
  // group decides which checks take part at all
  assign fp_grp  = req.group != GRP_NO_FP;
  assign a16_grp = req.group == GRP_FP_ALIGN16;
  assign mem     = req.mem_form;

  assign canon_ok = (&req.lin[63:`LSEC_CANON_MSB]) | ~(|req.lin[63:`LSEC_CANON_MSB]);
  // 33-bit sum so an operand wrapping past the top still counts as beyond
  assign last_byte = {1'b0, req.ea} + (a16_grp ? `LSEC_LAST_OP16 : `LSEC_LAST_OP8);
  assign beyond    = last_byte > `LSEC_RM_LIMIT;

  // undefined opcode class
  always_comb begin
    ud = 1'b0;
    if (st.em)                                     ud = 1'b1;
    if (!st.osfxsr)                                ud = 1'b1;
    if (req.lock_prefix)                           ud = 1'b1;
    if (|(req.feat_need & ~st.feat))               ud = 1'b1;
    if (fp_grp && req.simd_unmasked && !st.osxmm)  ud = 1'b1;
  end

  assign nm = st.ts;
  // the memory form of the no-fp conversion skips the x87 check
  assign mf = req.x87_pending && (fp_grp || !mem);

  assign ss = mem && req.seg_stack &&
              ((in_pm && req.seg_fail) ||
               (in_64 && !canon_ok));

  always_comb begin
    gp = 1'b0;
    if (mem && in_pm && req.seg_fail && !req.seg_stack) gp = 1'b1;
    if (mem && in_64 && !canon_ok && !req.seg_stack)    gp = 1'b1;
    if (mem && (is_real || is_v86) && beyond)           gp = 1'b1;
    if (mem && a16_grp && (|req.ea[3:0]))               gp = 1'b1;
  end

  assign pf = mem && !is_real && req.pf_fail;
  assign ac = mem && !a16_grp && !is_real && st.ac_en && (|req.ea[2:0]) &&
              (req.cpl == `LSEC_CPL_USER);
  assign xm = fp_grp && req.simd_unmasked && st.osxmm;

  // execute-category selection, first match wins
  always_comb begin
    flt = FLT_NONE;
    if (req.valid) begin
      if (ud)      flt = FLT_UD;
      else if (nm) flt = FLT_NM;
      else if (mf) flt = FLT_MF;
      else if (ss) flt = FLT_SS;
      else if (gp) flt = FLT_GP;
      else if (pf) flt = FLT_PF;
      else if (ac) flt = FLT_AC;
      else if (xm) flt = FLT_XM;
    end
  end

  // fixed major category order
  always_comb begin
    cat = CAT_NONE;
    if (pend.trap)                 cat = CAT_TRAP;
    else if (pend.intr)            cat = CAT_INTR;
    else if (pend.fetch)           cat = CAT_FETCH;
    else if (pend.decode)          cat = CAT_DECODE;
    else if (flt != FLT_NONE)      cat = CAT_EXEC;
  end

  assign setup  = psel && !penable;
  assign access = psel && penable;
  assign mapped = (paddr == `LSEC_OFS_CR0) || (paddr == `LSEC_OFS_CR4) ||
                  (paddr == `LSEC_OFS_FEAT) || (paddr == `LSEC_OFS_ALIGN) ||
                  (paddr == `LSEC_OFS_STATUS) || (paddr == `LSEC_OFS_COUNT);

  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (paddr)
      `LSEC_OFS_CR0: begin
        rd_word[`LSEC_BIT_EM] = st.em;
        rd_word[`LSEC_BIT_TS] = st.ts;
      end
      `LSEC_OFS_CR4: begin
        rd_word[`LSEC_BIT_OSFXSR] = st.osfxsr;
        rd_word[`LSEC_BIT_OSXMM]  = st.osxmm;
      end
      `LSEC_OFS_FEAT:   rd_word[`LSEC_FEAT_W-1:0] = st.feat;
      `LSEC_OFS_ALIGN:  rd_word[`LSEC_BIT_ACEN] = st.ac_en;
      `LSEC_OFS_STATUS: begin
        rd_word[`LSEC_ST_FAULT_LO +: 4] = st.res.fault;
        rd_word[`LSEC_ST_CAT_LO +: 4]   = st.res.cat;
        rd_word[`LSEC_ST_VEC_LO +: 8]   = st.res.vector;
      end
      `LSEC_OFS_COUNT:  rd_word[`LSEC_CNT_W-1:0] = st.cnt;
      default:          rd_word = 32'h0000_0000;
    endcase
  end

  always_comb begin
    next_st = st;
    // read data and error are staged in setup so both come from flops in access
    next_st.prdata  = (setup && !pwrite && mapped) ? rd_word : 32'h0000_0000;
    next_st.pslverr = setup && !mapped;
    if (access && pwrite) begin
      unique case (paddr)
        `LSEC_OFS_CR0: begin
          next_st.em = pwdata[`LSEC_BIT_EM];
          next_st.ts = pwdata[`LSEC_BIT_TS];
        end
        `LSEC_OFS_CR4: begin
          next_st.osfxsr = pwdata[`LSEC_BIT_OSFXSR];
          next_st.osxmm  = pwdata[`LSEC_BIT_OSXMM];
        end
        `LSEC_OFS_FEAT:  next_st.feat  = pwdata[`LSEC_FEAT_W-1:0];
        `LSEC_OFS_ALIGN: next_st.ac_en = pwdata[`LSEC_BIT_ACEN];
        `LSEC_OFS_COUNT: next_st.cnt   = '0;
        default: ;
      endcase
    end
    // a fault in the clearing cycle is still counted
    if (cat == CAT_EXEC)
      next_st.cnt = next_st.cnt + 16'h0001;

    next_st.res.valid     = req.valid || pend.trap || pend.intr || pend.fetch || pend.decode;
    next_st.res.cat       = cat;
    next_st.res.fault     = (cat == CAT_EXEC) ? flt : FLT_NONE;
    next_st.res.err_valid = 1'b0;
    next_st.res.err_code  = `LSEC_ERR_ZERO;
    next_st.res.vector    = `LSEC_VEC_NONE;
    if (cat == CAT_EXEC) begin
      unique case (flt)
        FLT_UD: next_st.res.vector = `LSEC_VEC_UD;
        FLT_NM: next_st.res.vector = `LSEC_VEC_NM;
        FLT_MF: next_st.res.vector = `LSEC_VEC_MF;
        FLT_SS: begin
          next_st.res.vector    = `LSEC_VEC_SS;
          next_st.res.err_valid = 1'b1;
        end
        FLT_GP: begin
          next_st.res.vector    = `LSEC_VEC_GP;
          next_st.res.err_valid = 1'b1;
        end
        FLT_PF: begin
          next_st.res.vector    = `LSEC_VEC_PF;
          next_st.res.err_valid = 1'b1;
          next_st.res.err_code  = req.pf_code;
        end
        FLT_AC: begin
          next_st.res.vector    = `LSEC_VEC_AC;
          next_st.res.err_valid = 1'b1;
        end
        FLT_XM: next_st.res.vector = `LSEC_VEC_XM;
        FLT_NONE: next_st.res.vector = `LSEC_VEC_NONE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st         <= '0;
      st.em      <= `LSEC_RST_EM;
      st.ts      <= `LSEC_RST_TS;
      st.osfxsr  <= `LSEC_RST_OSFXSR;
      st.osxmm   <= `LSEC_RST_OSXMM;
      st.ac_en   <= `LSEC_RST_ACEN;
      st.feat    <= `LSEC_RST_FEAT;
      st.res.cat <= CAT_NONE;
      st.res.fault <= FLT_NONE;
    end else begin
      st <= next_st;
    end
  end

  // zero wait states: every access phase completes at once
  assign pready  = access;
  assign prdata  = st.prdata;
  assign pslverr = st.pslverr;
  assign res     = st.res;

endmodule : lsec_check

// ### test/lsec_checker.sv
// concurrent checks on the ports of the exception checker
`include "lsec_params.svh"
module lsec_checker
  import lsec_pkg::*;
(
  // clock and reset
  input wire logic                    pclk,
  input wire logic                    presetn,
  // apb slave
  input wire logic                    psel,
  input wire logic                    penable,
  input wire logic                    pwrite,
  input wire logic [`LSEC_ADDR_W-1:0] paddr,
  input wire logic [31:0]             pwdata,
  input wire logic [31:0]             prdata,
  input wire logic                    pready,
  input wire logic                    pslverr,
  // pipeline
  input wire lsec_req_s               req,
  input wire lsec_pend_s              pend,
  input wire lsec_result_s            res
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_trap_first: assert property (pend.trap |=> res.valid && res.cat == CAT_TRAP && res.fault == FLT_NONE)
    else $error("trap pending did not win");
  a_intr_second: assert property (!pend.trap && pend.intr |=> res.cat == CAT_INTR)
    else $error("interrupt not second");
  a_decode_only: assert property (pend == 4'h1 |=> res.cat == CAT_DECODE && res.vector == 8'h00)
    else $error("decode category wrong");
  a_lock_undef: assert property (req.valid && req.lock_prefix && pend == 4'h0 |=> res.fault == FLT_UD)
    else $error("lock prefix not refused");
  a_simd_vec: assert property (res.fault == FLT_XM |-> res.vector == `LSEC_VEC_XM)
    else $error("simd fault vector wrong");
  a_real_no_page: assert property (req.valid && req.mode == MODE_REAL |=> res.fault != FLT_PF)
    else $error("page fault in real mode");
  a_page_code: assert property (res.fault == FLT_PF |-> res.err_code == $past(req.pf_code))
    else $error("page fault code wrong");
  a_zero_code: assert property (res.fault inside {FLT_SS, FLT_GP, FLT_AC} |-> res.err_code == 32'h0)
    else $error("error code not zero");
  a_idle_quiet: assert property (!req.valid && pend == 4'h0 |=> !res.valid)
    else $error("result without request");
  c_exec: cover property (res.cat == CAT_EXEC);
  c_clean: cover property (res.valid && res.cat == CAT_NONE);
  c_simd: cover property (res.fault == FLT_XM);
endmodule : lsec_checker
bind lsec_check lsec_checker lsec_checker_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pready, .pslverr, .req, .pend, .res);

// ### test/lsec_pipe_model.sv
// decode and execute stage model presenting one request per command
module lsec_pipe_model
  import lsec_pkg::*;
(
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // command from the bench
  input  wire logic       go,
  input  wire lsec_req_s  cmd,
  input  wire lsec_pend_s cmd_pend,
  // towards the checker
  output lsec_req_s       req,
  output lsec_pend_s      pend
);
  timeunit 1ns;
  timeprecision 1ns;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req  <= '0;
      pend <= '0;
    end else if (go) begin
      req  <= cmd;
      pend <= cmd_pend;
    end else begin
      // idle fields toggle so a stale operand is never mistaken for a live one
      // valid is the top field, so one assignment drops it and inverts the rest
      req  <= {1'b0, ~req[$bits(lsec_req_s)-2:0]};
      pend <= '0;
    end
  end
endmodule : lsec_pipe_model

// ### test/tb_lsec_check.sv
// self-checking bench of the legacy simd exception checker
`include "lsec_params.svh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin fail_count++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module tb_lsec_check
  import lsec_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic         pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, go = 0, er, pready, pslverr;
  logic [7:0]   paddr = 0;
  logic [31:0]  pwdata = 0, q, prdata;
  lsec_req_s    cmd = '0, req, b, r;
  lsec_pend_s   cmd_pend = '0, pend;
  lsec_result_s res;
  int           fail_count = 0, n_checks = 0;
  always #25 pclk = ~pclk;
  lsec_pipe_model lsec_pipe_model_i (.pclk(pclk), .presetn(presetn), .go(go), .cmd(cmd), .cmd_pend(cmd_pend),
    .req(req), .pend(pend));
  lsec_check lsec_check_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .req(req), .pend(pend),
    .res(res));
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] d, input logic e);
    apb(1'b0, a, 32'h0);
    `CHK(q, d)
    `CHK(er, e)
  endtask : rd
  task run(input lsec_req_s t, input lsec_pend_s p, input lsec_fault_e f, input lsec_cat_e c, input logic [7:0] v,
           input logic [31:0] e);
    @(posedge pclk);
    cmd <= t; cmd_pend <= p; go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    @(posedge pclk);
    #1;
    `CHK(res.valid, 1'b1)
    `CHK(res.fault, f)
    `CHK(res.cat, c)
    `CHK(res.vector, v)
    `CHK(res.err_valid, f inside {FLT_SS, FLT_GP, FLT_PF, FLT_AC})
    `CHK(res.err_code, e)
  endtask : run
  task give_verdict();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (6000) @(posedge pclk);
    fail_count++;
    give_verdict();
  end
  initial begin
    b = '0; b.valid = 1'b1; b.group = GRP_FP_NOALIGN; b.mode = MODE_PROT; b.mem_form = 1'b1;
    b.feat_need = 4'h1; b.ea = 32'h1000; b.lin = 64'h1000;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd(`LSEC_OFS_CR0, 32'h0, 1'b0);
    rd(`LSEC_OFS_FEAT, 32'hF, 1'b0);
    run(b, '0, FLT_UD, CAT_EXEC, `LSEC_VEC_UD, 0);
    rd(8'h20, 32'h0, 1'b1);
    wr(`LSEC_OFS_CR4, 32'h600);
    rd(`LSEC_OFS_CR4, 32'h600, 1'b0);
    run(b, '0, FLT_NONE, CAT_NONE, 8'h00, 0);
    r = b; r.lock_prefix = 1'b1;
    run(r, '0, FLT_UD, CAT_EXEC, `LSEC_VEC_UD, 0);
    for (int i = 0; i < 4; i++) run(r, 4'h8 >> i, FLT_NONE, lsec_cat_e'(i + 1), 8'h00, 0);
    run(r, 4'h6, FLT_NONE, CAT_INTR, 8'h00, 0);
    wr(`LSEC_OFS_FEAT, 32'h1);
    r = b; r.feat_need = 4'h2;
    run(r, '0, FLT_UD, CAT_EXEC, `LSEC_VEC_UD, 0);
    wr(`LSEC_OFS_FEAT, 32'hF);
    r = b; r.x87_pending = 1'b1;
    wr(`LSEC_OFS_CR0, 32'h4);
    run(r, '0, FLT_UD, CAT_EXEC, `LSEC_VEC_UD, 0);
    wr(`LSEC_OFS_CR0, 32'h8);
    run(r, '0, FLT_NM, CAT_EXEC, `LSEC_VEC_NM, 0);
    wr(`LSEC_OFS_CR0, 32'h0);
    run(r, '0, FLT_MF, CAT_EXEC, `LSEC_VEC_MF, 0);
    r.group = GRP_NO_FP; r.mem_form = 1'b0;
    run(r, '0, FLT_MF, CAT_EXEC, `LSEC_VEC_MF, 0);
    r.mem_form = 1'b1;
    run(r, '0, FLT_NONE, CAT_NONE, 8'h00, 0);
    r = b; r.seg_fail = 1'b1; r.seg_stack = 1'b1;
    run(r, '0, FLT_SS, CAT_EXEC, `LSEC_VEC_SS, 0);
    r.seg_stack = 1'b0;
    run(r, '0, FLT_GP, CAT_EXEC, `LSEC_VEC_GP, 0);
    r = b; r.mode = MODE_LONG; r.lin = 64'h0000_8000_0000_0000; r.seg_stack = 1'b1;
    run(r, '0, FLT_SS, CAT_EXEC, `LSEC_VEC_SS, 0);
    r.seg_stack = 1'b0;
    run(r, '0, FLT_GP, CAT_EXEC, `LSEC_VEC_GP, 0);
    r = b; r.mode = MODE_REAL; r.ea = 32'hFFF9; r.pf_fail = 1'b1;
    run(r, '0, FLT_GP, CAT_EXEC, `LSEC_VEC_GP, 0);
    r.ea = 32'hFFF8;
    run(r, '0, FLT_NONE, CAT_NONE, 8'h00, 0);
    r = b; r.group = GRP_FP_ALIGN16; r.ea = 32'h1008;
    run(r, '0, FLT_GP, CAT_EXEC, `LSEC_VEC_GP, 0);
    wr(`LSEC_OFS_ALIGN, 32'h1);
    r = b; r.cpl = 2'h3; r.ea = 32'h1004; r.pf_fail = 1'b1; r.pf_code = 32'h5;
    run(r, '0, FLT_PF, CAT_EXEC, `LSEC_VEC_PF, 32'h5);
    r.pf_fail = 1'b0;
    run(r, '0, FLT_AC, CAT_EXEC, `LSEC_VEC_AC, 0);
    r.mode = MODE_REAL;
    run(r, '0, FLT_NONE, CAT_NONE, 8'h00, 0);
    r = b; r.simd_unmasked = 1'b1;
    run(r, '0, FLT_XM, CAT_EXEC, `LSEC_VEC_XM, 0);
    r.group = GRP_NO_FP;
    run(r, '0, FLT_NONE, CAT_NONE, 8'h00, 0);
    wr(`LSEC_OFS_CR4, 32'h200);
    r.group = GRP_FP_NOALIGN;
    wr(`LSEC_OFS_COUNT, 32'h0);
    // status mirrors the result of every cycle, so its read must overlap the one cycle the fault stands
    fork
      run(r, '0, FLT_UD, CAT_EXEC, `LSEC_VEC_UD, 0);
      begin
        repeat (2) @(posedge pclk);
        rd(`LSEC_OFS_STATUS, 32'h651, 1'b0);
      end
    join
    rd(`LSEC_OFS_COUNT, 32'h1, 1'b0);
    // second reset in mid-run: control images fall back to their reset values
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(`LSEC_OFS_CR4, 32'h0, 1'b0);
    run(b, '0, FLT_UD, CAT_EXEC, `LSEC_VEC_UD, 0);
    give_verdict();
  end
endmodule : tb_lsec_check
